/* pkg/fbsm_cfg.svh */
// Offsets, field positions, reset values and counts of the fieldbus word mapper
// Functional notes
// - Run lit, error dark on station agreement; exchange only when expansion also agrees.
// - Incompatible version or fatal error: run off, error on, exchange stops.
// - Station number is configurable 1 to 64; answer only under it.
// - Five bit rates selectable: 156k, 625k, 2.5M, 5M, 10M.
// - Protocol version setting is version 1 or version 2.
// - Multipliers x2, x4, x8 only under version 2; version 1 allows x1.
// - Eight station/multiplier combinations; combination fixes input and output word counts.
// - One station x1: 4 in words, 16 in bits, 3 out words, 16 out bits.
// - Two stations x1: 8 in words, 32 in bits, 7 out words, 32 out bits.
// - Three stations x1: 12 in words, 48 bits, 11 out words, 48 bits.
// - Four stations x1: 16 in words, 64 bits, 15 out words, 64 bits.
// - One station x2: 8 in words, 16 bits, 7 out words, 16 bits.
// - Two stations x2: 16 in words, 48 bits, 15 out words, 48 bits.
// - One station x8: 32 in words, 64 bits, 31 out words, 64 bits.
// - Device acts as remote device station, never as master.
// - Last output word is system area, never carries user data.
// - Occupied station count must equal the master's, else no exchange.
`ifndef FBSM_CFG_SVH
`define FBSM_CFG_SVH
`define FBSM_A_CTRL 12'h000
`define FBSM_A_STAT 12'h004
`define FBSM_A_IRQ_ST 12'h008
`define FBSM_A_IRQ_MSK 12'h00C
`define FBSM_REGION_IN 4'h1
`define FBSM_REGION_OUT 4'h2
`define FBSM_CTRL_RST 32'h0000_0101
`define FBSM_STN_LSB 0
`define FBSM_VER_BIT 7
`define FBSM_OCC_LSB 8
`define FBSM_EXT_LSB 11
`define FBSM_RATE_LSB 13
`define FBSM_STN_MAX 7'h40
`define FBSM_RATE_MAX 3'h4
`define FBSM_RELAY_BASE 6'h20
`define FBSM_NSLOT 36
`define FBSM_RESP_OK 2'h0
`define FBSM_RESP_ERR 2'h2
`endif

/* pkg/fbsm_pkg.sv */
// Types shared by the fieldbus word mapper
package fbsm_pkg;
   typedef enum logic [1:0] {FBSM_X1, FBSM_X2, FBSM_X4, FBSM_X8} fbsm_ext_t;
   typedef enum logic [2:0] {FBSM_R156K, FBSM_R625K, FBSM_R2M5, FBSM_R5M, FBSM_R10M} fbsm_rate_t;
   typedef enum logic [1:0] {FBSM_ST_IDLE, FBSM_ST_HOLD, FBSM_ST_EXCH, FBSM_ST_FAULT} fbsm_state_t;
endpackage

/* design/fbsm_status.sv */
// Link state machine driving run and error indicators
`timescale 1ns/1ns
`default_nettype none
module fbsm_status (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic seen,
   input wire logic occ_agree,
   input wire logic ext_agree,
   input wire logic ver_ok,
   input wire logic fatal,
   output logic run_led,
   output logic err_led,
   output logic exch
);
   import fbsm_pkg::*;

   fbsm_state_t state_reg;
   fbsm_state_t state_next;

   //----------------------------------------
   // Next state from agreement and faults
   //----------------------------------------
   always_comb
   begin
      if (fatal || (seen && !ver_ok))
         state_next = FBSM_ST_FAULT;
      else if (!seen || !occ_agree)
         state_next = FBSM_ST_IDLE;
      else if (!ext_agree)
         state_next = FBSM_ST_HOLD;
      else
         state_next = FBSM_ST_EXCH;
   end

   // State and indicator flops
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_reg <= FBSM_ST_IDLE;
         run_led <= 1'b0;
         err_led <= 1'b0;
         exch <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         case (state_next)
            FBSM_ST_HOLD:
            begin
               run_led <= 1'b1;
               err_led <= 1'b0;
               exch <= 1'b0;
            end
            FBSM_ST_EXCH:
            begin
               run_led <= 1'b1;
               err_led <= 1'b0;
               exch <= 1'b1;
            end
            FBSM_ST_FAULT:
            begin
               run_led <= 1'b0;
               err_led <= 1'b1;
               exch <= 1'b0;
            end
            default:
            begin
               run_led <= 1'b0;
               err_led <= 1'b0;
               exch <= 1'b0;
            end
         endcase
      end
   end

   a_fault_stops_all: assert property (@(posedge aclk) disable iff (!aresetn) fatal |=> err_led && !run_led && !exch) else $error("fault did not stop exchange");
   a_agree_gives_exch: assert property (@(posedge aclk) disable iff (!aresetn) (seen && occ_agree && ext_agree && ver_ok && !fatal) |=> exch && run_led) else $error("agreement gave no exchange");
   a_ext_mismatch_hold: assert property (@(posedge aclk) disable iff (!aresetn) (seen && occ_agree && !ext_agree && ver_ok && !fatal) |=> run_led && !err_led && !exch) else $error("hold state wrong");
endmodule
`default_nettype wire

/* design/fbsm_top.sv */
// Fieldbus remote station word mapper with register access over AXI4-Lite
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "fbsm_cfg.svh"
module fbsm_top (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [11:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [11:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic lk_cfg_valid,
   input wire logic [2:0] lk_cfg_occ,
   input wire fbsm_pkg::fbsm_ext_t lk_cfg_ext,
   input wire logic lk_cfg_ver,
   input wire logic lk_fatal,
   input wire logic lk_rx_valid,
   input wire logic [6:0] lk_rx_stn,
   input wire logic [5:0] lk_rx_idx,
   input wire logic [15:0] lk_rx_data,
   input wire logic lk_cycle_end,
   input wire logic lk_tx_req,
   input wire logic [6:0] lk_tx_stn,
   input wire logic [5:0] lk_tx_idx,
   output logic lk_tx_valid,
   output logic [15:0] lk_tx_data,
   output logic [6:0] lk_station,
   output fbsm_pkg::fbsm_rate_t lk_rate,
   output logic run_led,
   output logic err_led,
   output logic irq
);
   import fbsm_pkg::*;

   //----------------------------------------
   // Functions
   //----------------------------------------
   // Data words for a combination
   function automatic logic [5:0] fn_words(input logic [2:0] occ, input fbsm_ext_t e);
      case (e)
         FBSM_X1: fn_words = {1'b0, occ, 2'b00};
         FBSM_X2: fn_words = {occ, 3'b000};
         FBSM_X4: fn_words = 6'h10;
         default: fn_words = 6'h20;
      endcase
   endfunction

   // Relay words of 16 bits for a combination
   function automatic logic [2:0] fn_rly(input logic [2:0] occ, input fbsm_ext_t e);
      case (e)
         FBSM_X1: fn_rly = occ;
         FBSM_X2: fn_rly = (occ == 3'h1) ? 3'h1 : 3'h3;
         FBSM_X4: fn_rly = 3'h2;
         default: fn_rly = 3'h4;
      endcase
   endfunction

   // Slot mapped; output side drops the system word
   function automatic logic fn_slot_ok(input logic [5:0] idx, input logic [5:0] words,
                                       input logic [2:0] rly, input logic outs);
      logic [5:0] top;
      top = outs ? words - 6'h01 : words;
      if (idx >= `FBSM_RELAY_BASE)
         fn_slot_ok = (idx - `FBSM_RELAY_BASE) < {3'h0, rly};
      else
         fn_slot_ok = idx < top;
   endfunction

   // Legal setting word
   function automatic logic fn_legal(input logic [31:0] c);
      logic [6:0] stn;
      logic [2:0] occ;
      logic [1:0] ext;
      logic ok;
      stn = c[`FBSM_STN_LSB +: 7];
      occ = c[`FBSM_OCC_LSB +: 3];
      ext = c[`FBSM_EXT_LSB +: 2];
      ok = (stn != 7'h00) && (stn <= `FBSM_STN_MAX);
      ok = ok && (c[`FBSM_RATE_LSB +: 3] <= `FBSM_RATE_MAX);
      case (ext)
         2'h0: ok = ok && (occ != 3'h0) && (occ <= 3'h4);
         2'h1: ok = ok && c[`FBSM_VER_BIT] && (occ != 3'h0) && (occ <= 3'h2);
         default: ok = ok && c[`FBSM_VER_BIT] && (occ == 3'h1);
      endcase
      fn_legal = ok;
   endfunction

   // Byte lane merge
   function automatic logic [31:0] fn_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] strb);
      for (int b = 0; b < 4; b++)
         fn_merge[8*b +: 8] = strb[b] ? nw[8*b +: 8] : old[8*b +: 8];
   endfunction

   //----------------------------------------
   // State
   //----------------------------------------
   logic [31:0] ctrl_reg;
   logic [2:0] m_occ_reg;
   fbsm_ext_t m_ext_reg;
   logic m_ver_reg;
   logic m_seen_reg;
   logic aw_held_reg;
   logic w_held_reg;
   logic [11:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic [3:0] irq_st_reg;
   logic [3:0] irq_msk_reg;
   logic run_q_reg;
   logic err_q_reg;
   logic [15:0] out_mem [`FBSM_NSLOT];
   logic [15:0] in_mem [`FBSM_NSLOT];
   logic [15:0] rx_sh [`FBSM_NSLOT];
   logic [15:0] tx_sh [`FBSM_NSLOT];
   logic [5:0] tx_idx_reg;
   logic exch;
   logic [6:0] stn;
   logic ver;
   logic [2:0] occ;
   fbsm_ext_t ext;
   logic [5:0] words;
   logic [2:0] rly;
   logic wr_fire;
   logic [5:0] wr_idx;
   logic wr_out;
   logic wr_ctrl;
   logic [31:0] ctrl_merged;
   logic cfg_rej;
   logic commit;
   logic [3:0] events;
   logic [3:0] w1c;
   logic [31:0] rd_mux;
   logic rd_err;
   logic wr_err;
   logic [5:0] rd_idx;

   // Setting fields
   assign stn = ctrl_reg[`FBSM_STN_LSB +: 7];
   assign ver = ctrl_reg[`FBSM_VER_BIT];
   assign occ = ctrl_reg[`FBSM_OCC_LSB +: 3];
   assign ext = fbsm_ext_t'(ctrl_reg[`FBSM_EXT_LSB +: 2]);
   assign words = fn_words(occ, ext);
   assign rly = fn_rly(occ, ext);

   //----------------------------------------
   // Run and error indicators
   //----------------------------------------
   fbsm_status u_status (
      .aclk(aclk),
      .aresetn(aresetn),
      .seen(m_seen_reg),
      .occ_agree(m_occ_reg == occ),
      .ext_agree(m_ext_reg == ext),
      .ver_ok(m_ver_reg || !ver),
      .fatal(lk_fatal),
      .run_led(run_led),
      .err_led(err_led),
      .exch(exch)
   );

   // Master setting as announced on the link
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         m_occ_reg <= 3'h0;
         m_ext_reg <= FBSM_X1;
         m_ver_reg <= 1'b0;
         m_seen_reg <= 1'b0;
      end
      else if (lk_cfg_valid)
      begin
         m_occ_reg <= lk_cfg_occ;
         m_ext_reg <= lk_cfg_ext;
         m_ver_reg <= lk_cfg_ver;
         m_seen_reg <= 1'b1;
      end
   end

   //----------------------------------------
   // AXI4-Lite write path
   //----------------------------------------
   assign wr_fire = aw_held_reg && w_held_reg && !bvalid;
   assign wr_idx = aw_addr_reg[7:2];
   assign wr_ctrl = (aw_addr_reg == `FBSM_A_CTRL);
   assign wr_out = (aw_addr_reg[11:8] == `FBSM_REGION_OUT) && fn_slot_ok(wr_idx, words, rly, 1'b1);
   assign ctrl_merged = fn_merge(ctrl_reg, w_data_reg, w_strb_reg);
   assign cfg_rej = wr_fire && wr_ctrl && !fn_legal(ctrl_merged);
   assign w1c = (wr_fire && aw_addr_reg == `FBSM_A_IRQ_ST) ? (w_data_reg[3:0] & {4{w_strb_reg[0]}}) : 4'h0;
   assign wr_err = !(wr_ctrl || wr_out || aw_addr_reg == `FBSM_A_STAT || aw_addr_reg == `FBSM_A_IRQ_ST
                     || aw_addr_reg == `FBSM_A_IRQ_MSK);

   // Write address capture
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awready <= 1'b0;
         aw_held_reg <= 1'b0;
         aw_addr_reg <= 12'h000;
      end
      else
      begin
         awready <= 1'b0;
         if (awvalid && awready)
            aw_held_reg <= 1'b1;
         else if (wr_fire)
            aw_held_reg <= 1'b0;
         if (awvalid && !awready && !aw_held_reg && !bvalid)
         begin
            awready <= 1'b1;
            aw_addr_reg <= awaddr;
         end
      end
   end

   // Write data capture
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wready <= 1'b0;
         w_held_reg <= 1'b0;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
      end
      else
      begin
         wready <= 1'b0;
         if (wvalid && wready)
            w_held_reg <= 1'b1;
         else if (wr_fire)
            w_held_reg <= 1'b0;
         if (wvalid && !wready && !w_held_reg && !bvalid)
         begin
            wready <= 1'b1;
            w_data_reg <= wdata;
            w_strb_reg <= wstrb;
         end
      end
   end

   // Write response
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid <= 1'b0;
         bresp <= `FBSM_RESP_OK;
      end
      else if (wr_fire)
      begin
         bvalid <= 1'b1;
         bresp <= wr_err ? `FBSM_RESP_ERR : `FBSM_RESP_OK;
      end
      else if (bready)
         bvalid <= 1'b0;
   end

   // Setting register, illegal words refused
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         ctrl_reg <= `FBSM_CTRL_RST;
      else if (wr_fire && wr_ctrl && fn_legal(ctrl_merged))
         ctrl_reg <= ctrl_merged;
   end

   // Interrupt mask
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         irq_msk_reg <= 4'h0;
      else if (wr_fire && aw_addr_reg == `FBSM_A_IRQ_MSK)
         irq_msk_reg <= 4'(fn_merge({28'h000_0000, irq_msk_reg}, w_data_reg, w_strb_reg));
   end

   // Output words written by the controller
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         for (int i = 0; i < `FBSM_NSLOT; i++)
            out_mem[i] <= 16'h0000;
      end
      else if (wr_fire && wr_out)
         out_mem[wr_idx] <= 16'(fn_merge({16'h0000, out_mem[wr_idx]}, w_data_reg, w_strb_reg));
   end

   //----------------------------------------
   // AXI4-Lite read path
   //----------------------------------------
   assign rd_idx = araddr[7:2];

   // Read decode
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      rd_err = 1'b0;
      if (araddr == `FBSM_A_CTRL)
         rd_mux = ctrl_reg;
      else if (araddr == `FBSM_A_STAT)
         rd_mux = {18'h0_0000, words, 1'b0, m_seen_reg, m_ver_reg || !ver, m_ext_reg == ext,
                   m_occ_reg == occ, exch, err_led, run_led};
      else if (araddr == `FBSM_A_IRQ_ST)
         rd_mux = {28'h000_0000, irq_st_reg};
      else if (araddr == `FBSM_A_IRQ_MSK)
         rd_mux = {28'h000_0000, irq_msk_reg};
      else if (araddr[11:8] == `FBSM_REGION_IN && fn_slot_ok(rd_idx, words, rly, 1'b0))
         rd_mux = {16'h0000, in_mem[rd_idx]};
      else if (araddr[11:8] == `FBSM_REGION_OUT && fn_slot_ok(rd_idx, words, rly, 1'b1))
         rd_mux = {16'h0000, out_mem[rd_idx]};
      else
         rd_err = 1'b1;
   end

   // Read handshake and data
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= `FBSM_RESP_OK;
      end
      else
      begin
         arready <= arvalid && !arready && !rvalid;
         if (arvalid && arready)
         begin
            rvalid <= 1'b1;
            rdata <= rd_mux;
            rresp <= rd_err ? `FBSM_RESP_ERR : `FBSM_RESP_OK;
         end
         else if (rready)
            rvalid <= 1'b0;
      end
   end

   //----------------------------------------
   // Cyclic exchange with the master
   //----------------------------------------
   assign commit = lk_cycle_end && exch;

   // Receive staging, own station only
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         for (int i = 0; i < `FBSM_NSLOT; i++)
            rx_sh[i] <= 16'h0000;
      end
      else if (lk_rx_valid && exch && lk_rx_stn == stn && fn_slot_ok(lk_rx_idx, words, rly, 1'b0))
         rx_sh[lk_rx_idx] <= lk_rx_data;
   end

   // Input commit at cycle end
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         for (int i = 0; i < `FBSM_NSLOT; i++)
            in_mem[i] <= 16'h0000;
      end
      else if (commit)
      begin
         for (int i = 0; i < `FBSM_NSLOT; i++)
            if (fn_slot_ok(6'(i), words, rly, 1'b0))
               in_mem[i] <= rx_sh[i];
      end
   end

   // Output snapshot, system word forced to zero
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         for (int i = 0; i < `FBSM_NSLOT; i++)
            tx_sh[i] <= 16'h0000;
      end
      else if (commit)
      begin
         for (int i = 0; i < `FBSM_NSLOT; i++)
            tx_sh[i] <= fn_slot_ok(6'(i), words, rly, 1'b1) ? out_mem[i] : 16'h0000;
      end
   end

   // Answer polls only, never start a transfer
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         lk_tx_valid <= 1'b0;
         lk_tx_data <= 16'h0000;
         tx_idx_reg <= 6'h00;
      end
      else
      begin
         lk_tx_valid <= lk_tx_req && exch && lk_tx_stn == stn;
         tx_idx_reg <= lk_tx_idx;
         lk_tx_data <= fn_slot_ok(lk_tx_idx, words, rly, 1'b1) ? tx_sh[lk_tx_idx] : 16'h0000;
      end
   end

   // Station and rate driven to the link
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         lk_station <= 7'h01;
         lk_rate <= FBSM_R156K;
      end
      else
      begin
         lk_station <= stn;
         lk_rate <= fbsm_rate_t'(ctrl_reg[`FBSM_RATE_LSB +: 3]);
      end
   end

   //----------------------------------------
   // Interrupts
   //----------------------------------------
   assign events = {cfg_rej, run_q_reg && !run_led, err_led && !err_q_reg, commit};

   // Sticky status, set beats clear
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         irq_st_reg <= 4'h0;
         run_q_reg <= 1'b0;
         err_q_reg <= 1'b0;
         irq <= 1'b0;
      end
      else
      begin
         irq_st_reg <= (irq_st_reg & ~w1c) | events;
         run_q_reg <= run_led;
         err_q_reg <= err_led;
         irq <= |(irq_st_reg & irq_msk_reg);
      end
   end

   //----------------------------------------
   // Checks
   //----------------------------------------
   a_station_in_range: assert property (@(posedge aclk) disable iff (!aresetn) stn != 7'h00 && stn <= `FBSM_STN_MAX) else $error("station out of range");
   a_rate_in_range: assert property (@(posedge aclk) disable iff (!aresetn) ctrl_reg[`FBSM_RATE_LSB +: 3] <= `FBSM_RATE_MAX) else $error("bad rate code");
   a_ext_needs_v2: assert property (@(posedge aclk) disable iff (!aresetn) ext != FBSM_X1 |-> ver) else $error("multiplier under version 1");
   a_combo_words: assert property (@(posedge aclk) disable iff (!aresetn) (ext == FBSM_X8) |-> words == 6'h20 && rly == 3'h4 && occ == 3'h1) else $error("bad combination");
   a_commit_copies: assert property (@(posedge aclk) disable iff (!aresetn) commit |=> in_mem[0] == $past(rx_sh[0])) else $error("input not committed");
   a_sys_word_zero: assert property (@(posedge aclk) disable iff (!aresetn) lk_tx_valid && tx_idx_reg == words - 6'h01 |-> lk_tx_data == 16'h0000) else $error("system word leaked");
   a_no_tx_idle: assert property (@(posedge aclk) disable iff (!aresetn) !exch |=> !lk_tx_valid) else $error("answer without exchange");
   a_irq_from_status: assert property (@(posedge aclk) disable iff (!aresetn) (|(irq_st_reg & irq_msk_reg)) |=> irq) else $error("interrupt missing");
   a_x1_one_station: assert property (@(posedge aclk) disable iff (!aresetn) (ext == FBSM_X1 && occ == 3'h1) |-> words == 6'h04 && rly == 3'h1) else $error("one station sizes wrong");
endmodule
`default_nettype wire

/* bench/fbsm_master_model.sv */
// Fieldbus master model driving the link side of the mapper
`timescale 1ns/1ns
`default_nettype none
module fbsm_master (
   input wire logic aclk,
   output logic lk_cfg_valid,
   output logic [2:0] lk_cfg_occ,
   output fbsm_pkg::fbsm_ext_t lk_cfg_ext,
   output logic lk_cfg_ver,
   output logic lk_rx_valid,
   output logic [6:0] lk_rx_stn,
   output logic [5:0] lk_rx_idx,
   output logic [15:0] lk_rx_data,
   output logic lk_cycle_end,
   output logic lk_tx_req,
   output logic [6:0] lk_tx_stn,
   output logic [5:0] lk_tx_idx,
   input wire logic lk_tx_valid,
   input wire logic [15:0] lk_tx_data
);
   import fbsm_pkg::*;
   // Idle link at time zero
   initial
   begin
      {lk_cfg_valid, lk_cfg_occ, lk_cfg_ver, lk_rx_valid, lk_rx_stn, lk_rx_idx} = '0;
      {lk_rx_data, lk_cycle_end, lk_tx_req, lk_tx_stn, lk_tx_idx} = '0;
      lk_cfg_ext = FBSM_X1;
   end
   // Announce master configuration for one cycle
   task automatic cfg(input logic [2:0] o, input fbsm_ext_t e, input logic v);
      lk_cfg_valid <= 1'b1;
      lk_cfg_occ <= o;
      lk_cfg_ext <= e;
      lk_cfg_ver <= v;
      @(posedge aclk);
      lk_cfg_valid <= 1'b0;
      @(posedge aclk);
   endtask
   // One input word; data scrambled when released
   task automatic send(input logic [6:0] s, input logic [5:0] i, input logic [15:0] d);
      lk_rx_valid <= 1'b1;
      lk_rx_stn <= s;
      lk_rx_idx <= i;
      lk_rx_data <= d;
      @(posedge aclk);
      lk_rx_valid <= 1'b0;
      lk_rx_data <= ~d;
      @(posedge aclk);
   endtask
   // End of one cyclic exchange
   task automatic done();
      lk_cycle_end <= 1'b1;
      @(posedge aclk);
      lk_cycle_end <= 1'b0;
      @(posedge aclk);
   endtask
   // Poll an output word; answer sampled one cycle after the request
   task automatic poll(input logic [6:0] s, input logic [5:0] i, output logic ok, output logic [15:0] d);
      lk_tx_req <= 1'b1;
      lk_tx_stn <= s;
      lk_tx_idx <= i;
      @(posedge aclk);
      lk_tx_req <= 1'b0;
      @(posedge aclk);
      ok = lk_tx_valid;
      d = lk_tx_data;
   endtask
endmodule
`default_nettype wire

/* bench/test_fieldbus_slave_word_mapper.sv */
// Self-checking bench of the fieldbus word mapper
`timescale 1ns/1ns
`default_nettype none
`include "fbsm_cfg.svh"
module test_fieldbus_slave_word_mapper;
   import fbsm_pkg::*;
   localparam logic [1:0] OK = `FBSM_RESP_OK;
   localparam logic [1:0] ER = `FBSM_RESP_ERR;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, lk_fatal = 1'b0;
   logic bready = 1'b1, rready = 1'b1;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic [31:0] wdata = 32'h0000_0000;
   logic [3:0] wstrb = 4'hf;
   logic awready, wready, bvalid, arready, rvalid, lk_tx_valid, run_led, err_led, irq, ok;
   logic lk_cfg_valid, lk_cfg_ver, lk_rx_valid, lk_cycle_end, lk_tx_req;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [15:0] lk_rx_data, lk_tx_data, txd;
   logic [6:0] lk_station, lk_rx_stn, lk_tx_stn;
   logic [5:0] lk_rx_idx, lk_tx_idx;
   logic [2:0] lk_cfg_occ;
   fbsm_ext_t lk_cfg_ext;
   fbsm_rate_t lk_rate;
   int n_errors = 0, samples_checked = 0;
   // 100 MHz clock
   always #5 aclk = ~aclk;
   fbsm_top dut_u (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
      .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .lk_cfg_valid,
      .lk_cfg_occ, .lk_cfg_ext, .lk_cfg_ver, .lk_fatal, .lk_rx_valid, .lk_rx_stn, .lk_rx_idx, .lk_rx_data,
      .lk_cycle_end, .lk_tx_req, .lk_tx_stn, .lk_tx_idx, .lk_tx_valid, .lk_tx_data, .lk_station, .lk_rate,
      .run_led, .err_led, .irq);
   fbsm_master master_u (.aclk, .lk_cfg_valid, .lk_cfg_occ, .lk_cfg_ext, .lk_cfg_ver, .lk_rx_valid,
      .lk_rx_stn, .lk_rx_idx, .lk_rx_data, .lk_cycle_end, .lk_tx_req, .lk_tx_stn, .lk_tx_idx,
      .lk_tx_valid, .lk_tx_data);
   // ----------------------------------------
   // Bus and compare tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chkb(input logic got, input logic exp);
      chk(32'(got), 32'(exp));
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge aclk);
   endtask
   task automatic hang();
      n_errors++;
      tally_and_finish();
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      for (n = 0; n < 64 && (n == 0 || !bvalid); n++)
      begin
         @(posedge aclk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
      end
      if (!bvalid)
         hang();
      chk(32'(bresp), 32'(er));
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
      int n;
      araddr <= a;
      arvalid <= 1'b1;
      for (n = 0; n < 64 && (n == 0 || !rvalid); n++)
      begin
         @(posedge aclk);
         if (arready)
            arvalid <= 1'b0;
      end
      if (!rvalid)
         hang();
      chk(rdata, ed);
      chk(32'(rresp), 32'(er));
   endtask
   function automatic logic [31:0] ctrl(logic [6:0] s, logic v, logic [2:0] o, fbsm_ext_t e, logic [2:0] r);
      return {16'h0000, r, e, o, v, s};
   endfunction
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_ctrl();
      rd(`FBSM_A_CTRL, `FBSM_CTRL_RST, OK);
      for (int i = 0; i < 5; i++)
      begin
         wr(`FBSM_A_CTRL, ctrl(7'h03, 1'b0, 3'h1, FBSM_X1, 3'(i)), OK);
         rd(`FBSM_A_CTRL, ctrl(7'h03, 1'b0, 3'h1, FBSM_X1, 3'(i)), OK);
         chk(32'(lk_rate), 32'(i));
      end
      chk(32'(lk_station), 32'h0000_0003);
      wr(`FBSM_A_CTRL, ctrl(7'h03, 1'b0, 3'h1, FBSM_X2, 3'h0), OK);
      wr(`FBSM_A_CTRL, ctrl(7'h41, 1'b0, 3'h1, FBSM_X1, 3'h0), OK);
      wr(`FBSM_A_CTRL, ctrl(7'h03, 1'b1, 3'h3, FBSM_X2, 3'h0), OK);
      rd(`FBSM_A_CTRL, ctrl(7'h03, 1'b0, 3'h1, FBSM_X1, 3'h4), OK);
      rd(`FBSM_A_IRQ_ST, 32'h0000_0008, OK);
      wr(`FBSM_A_CTRL, ctrl(7'h03, 1'b1, 3'h1, FBSM_X2, 3'h0), OK);
      rd(`FBSM_A_CTRL, ctrl(7'h03, 1'b1, 3'h1, FBSM_X2, 3'h0), OK);
      $display("test ctrl done");
   endtask
   task automatic t_exch();
      wr(`FBSM_A_CTRL, ctrl(7'h03, 1'b0, 3'h1, FBSM_X1, 3'h2), OK);
      wr(`FBSM_A_IRQ_MSK, 32'h0000_0001, OK);
      chkb(irq, 1'b0);
      master_u.cfg(3'h1, FBSM_X1, 1'b0);
      cyc(3);
      chkb(run_led, 1'b1);
      chkb(err_led, 1'b0);
      master_u.send(7'h03, 6'h00, 16'h1111);
      master_u.send(7'h03, 6'h03, 16'h3333);
      master_u.send(7'h03, 6'h20, 16'ha5a5);
      master_u.send(7'h05, 6'h01, 16'hdead);
      rd(12'h100, 32'h0000_0000, OK);
      master_u.done();
      cyc(2);
      chkb(irq, 1'b1);
      rd(12'h100, 32'h0000_1111, OK);
      rd(12'h10C, 32'h0000_3333, OK);
      rd(12'h180, 32'h0000_a5a5, OK);
      rd(12'h104, 32'h0000_0000, OK);
      rd(12'h110, 32'h0000_0000, ER);
      rd(12'h184, 32'h0000_0000, ER);
      wr(`FBSM_A_IRQ_ST, 32'h0000_0009, OK);
      cyc(2);
      chkb(irq, 1'b0);
      wr(12'h200, 32'h0000_00c3, OK);
      wr(12'h208, 32'h0000_0c33, OK);
      master_u.done();
      master_u.poll(7'h03, 6'h00, ok, txd);
      chk(32'(txd), 32'h0000_00c3);
      master_u.poll(7'h03, 6'h02, ok, txd);
      chk(32'(txd), 32'h0000_0c33);
      master_u.poll(7'h03, 6'h03, ok, txd);
      chk(32'(txd), 32'h0000_0000);
      master_u.poll(7'h04, 6'h00, ok, txd);
      chkb(ok, 1'b0);
      $display("test exchange done");
   endtask
   task automatic t_state();
      master_u.cfg(3'h2, FBSM_X1, 1'b0);
      cyc(3);
      chkb(run_led | err_led, 1'b0);
      master_u.poll(7'h03, 6'h00, ok, txd);
      chkb(ok, 1'b0);
      master_u.cfg(3'h1, FBSM_X2, 1'b1);
      cyc(3);
      chkb(run_led, 1'b1);
      master_u.poll(7'h03, 6'h00, ok, txd);
      chkb(ok, 1'b0);
      wr(`FBSM_A_CTRL, ctrl(7'h03, 1'b1, 3'h1, FBSM_X1, 3'h0), OK);
      master_u.cfg(3'h1, FBSM_X1, 1'b0);
      cyc(3);
      chkb(err_led & ~run_led, 1'b1);
      wr(`FBSM_A_CTRL, ctrl(7'h03, 1'b0, 3'h1, FBSM_X1, 3'h0), OK);
      master_u.cfg(3'h1, FBSM_X1, 1'b0);
      lk_fatal <= 1'b1;
      cyc(3);
      chkb(err_led & ~run_led, 1'b1);
      master_u.poll(7'h03, 6'h00, ok, txd);
      chkb(ok, 1'b0);
      $display("test state done");
   endtask
   // ----------------------------------------
   // Main sequence and verdict
   // ----------------------------------------
   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial
   begin
      cyc(2);
      aresetn <= 1'b1;
      cyc(1);
      t_ctrl();
      t_exch();
      t_state();
      tally_and_finish();
   end
endmodule
`default_nettype wire
